// [hw/apm_pkg.sv]
// package: constants, offsets and state types for the power mode control
package apm_pkg;

  // apb register map (byte addresses)
  localparam logic [7:0] APM_CTRL_OFS   = 8'h00;
  localparam logic [7:0] APM_STATUS_OFS = 8'h04;

  // control register field positions
  localparam int APM_PF_LO_BIT   = 0;
  localparam int APM_PF_HI_BIT   = 1;
  localparam int APM_SWCONV_BIT  = 2;
  localparam int APM_SWCAL_BIT   = 3;

  // status register field positions
  localparam int APM_ST_STATE_LSB = 0;
  localparam int APM_ST_BUSY_BIT  = 2;
  localparam int APM_ST_READY_BIT = 3;
  localparam int APM_ST_REF_BIT   = 4;
  localparam int APM_ST_CORE_BIT  = 5;
  localparam int APM_ST_PCAL_BIT  = 6;

  // reset value of the power field
  localparam logic [1:0] APM_PF_RESET = 2'h0;

  // timing
  localparam int APM_CLK_MHZ     = 125;
  localparam int APM_WAKE_NS     = 5000;
  localparam int APM_WAKE_CYC    = (APM_WAKE_NS * APM_CLK_MHZ + 999) / 1000;
  localparam int APM_CONV_CYC    = 575;
  localparam int APM_CAL_CYC     = 7812;
  localparam int APM_PCAL_CYC    = 4000000;
  localparam int APM_CNT_W       = 23;
  localparam int APM_SYNC_CYC    = 4;

  // power state seen by the analog circuitry
  typedef enum logic [1:0] {
    APM_FULL_DOWN,
    APM_PART_DOWN,
    APM_WAKING,
    APM_AWAKE
  } apm_pwr_t;

  // activity sequencer state
  typedef enum logic [1:0] {
    APM_IDLE,
    APM_ARMED,
    APM_CONVERT,
    APM_CALIB
  } apm_act_t;

endpackage : apm_pkg

// [hw/apm_power_ctrl.sv]
// power mode control: apb registers, pin handling, power state machine
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module apm_power_ctrl
#(
  parameter int POWERON_CAL_CYC = apm_pkg::APM_PCAL_CYC,
  parameter int CAL_CYC         = apm_pkg::APM_CAL_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_allow,
  input  wire logic        conversion_start_n,
  input  wire logic        cal_req_n,
  output logic             busy,
  output logic             core_power_on,
  output logic             ref_power_on,
  output logic             ready
);
  import apm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic allow_s;
  logic start_n_s;
  logic cal_n_s;

  apm_sync u_sync_allow (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .rst_val(1'b1),
    .pin(power_allow), .level(allow_s));
  apm_sync u_sync_start (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .rst_val(1'b1),
    .pin(conversion_start_n), .level(start_n_s));
  apm_sync u_sync_cal (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .rst_val(1'b1),
    .pin(cal_req_n), .level(cal_n_s));

  logic start_n_d_ff;
  logic start_fall;
  logic start_rise;

  // edge detection on the filtered start level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_n_d_ff <= 1'b1;
    else if (clk_en)
      start_n_d_ff <= start_n_s;
  end
  assign start_fall = clk_en && start_n_d_ff && !start_n_s;
  assign start_rise = clk_en && !start_n_d_ff && start_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic [1:0] pfield_ff;
  logic       apb_wr;
  logic       apb_rd;
  logic       ctrl_hit;
  logic       stat_hit;
  logic       sw_conv;
  logic       sw_cal;

  assign pready   = 1'b1;
  assign ctrl_hit = (paddr == APM_CTRL_OFS);
  assign stat_hit = (paddr == APM_STATUS_OFS);
  assign pslverr  = psel && penable && !(ctrl_hit || stat_hit);
  assign apb_wr   = clk_en && psel && penable && pwrite && ctrl_hit;
  assign apb_rd   = psel && !penable && !pwrite;
  assign sw_conv  = apb_wr && pwdata[APM_SWCONV_BIT];
  assign sw_cal   = apb_wr && pwdata[APM_SWCAL_BIT];

  // power field register, zero after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pfield_ff <= APM_PF_RESET;
    else if (apb_wr)
      pfield_ff <= {pwdata[APM_PF_HI_BIT], pwdata[APM_PF_LO_BIT]};
  end

  logic power_field_hi;
  logic power_field_lo;
  assign power_field_hi = pfield_ff[1];
  assign power_field_lo = pfield_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // activity sequencer: power-on calibration, calibration, conversion
  apm_act_t act_ff;
  logic [2:0] settle_ff;
  logic     settled;
  logic     pcal_pend;
  logic     pcal_ff;
  logic     t_load;
  logic [APM_CNT_W-1:0] t_count;
  logic     t_busy;
  logic     t_done;
  logic     act_busy;
  logic     want_up;
  logic     awake;

  apm_timer u_act_timer (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .load(t_load),
    .count(t_count), .busy(t_busy), .done(t_done));

  // the calibration strap is judged once the pin filters have settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_ff <= 3'h0;
    else if (clk_en && settle_ff != 3'(APM_SYNC_CYC + 1))
      settle_ff <= settle_ff + 3'h1;
  end
  assign settled   = (settle_ff >= 3'(APM_SYNC_CYC));
  assign pcal_pend = (settle_ff == 3'(APM_SYNC_CYC)) && !cal_n_s;

  // next activity and timer load
  always_comb
  begin
    t_load  = 1'b0;
    t_count = '0;
    if (act_ff == APM_IDLE && pcal_pend)
    begin
      t_load  = clk_en;
      t_count = APM_CNT_W'(POWERON_CAL_CYC);
    end
    else if (act_ff == APM_IDLE && sw_cal)
    begin
      t_load  = 1'b1;
      t_count = APM_CNT_W'(CAL_CYC);
    end
    else if (act_ff == APM_IDLE && sw_conv && awake)
    begin
      t_load  = 1'b1;
      t_count = APM_CNT_W'(APM_CONV_CYC);
    end
    else if (act_ff == APM_ARMED && start_rise && awake)
    begin
      t_load  = 1'b1;
      t_count = APM_CNT_W'(APM_CONV_CYC);
    end
  end

  // activity state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_ff  <= APM_IDLE;
      pcal_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (act_ff)
        APM_IDLE:
        begin
          if (pcal_pend)
          begin
            act_ff  <= APM_CALIB;
            pcal_ff <= 1'b1;
          end
          else if (sw_cal)
            act_ff <= APM_CALIB;
          else if (sw_conv && awake)
            act_ff <= APM_CONVERT;
          else if (start_fall)
            act_ff <= APM_ARMED;
        end
        APM_ARMED:
        begin
          if (start_rise)
            act_ff <= awake ? APM_CONVERT : APM_IDLE;
        end
        APM_CONVERT:
        begin
          if (t_done)
            act_ff <= APM_IDLE;
        end
        APM_CALIB:
        begin
          if (t_done)
          begin
            act_ff  <= APM_IDLE;
            pcal_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  assign act_busy = (act_ff == APM_CONVERT) || (act_ff == APM_CALIB);
  assign busy     = act_busy;

  ////////////////////////////////////////////////////////////////////////////
  // power decision, evaluated every cycle
  logic part_req;

  always_comb
  begin
    want_up  = 1'b0;
    part_req = 1'b0;
    unique case (pfield_ff)
      2'h0: want_up = (allow_s && settled) || act_busy ||
                      (act_ff == APM_ARMED);
      2'h1: want_up = 1'b1;
      2'h2: want_up = pcal_ff;
      2'h3:
      begin
        want_up  = act_busy || (act_ff == APM_ARMED);
        part_req = !want_up;
      end
    endcase
    if (pcal_ff)
      want_up = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state machine with wake-up delay
  apm_pwr_t pwr_ff;
  logic     w_load;
  logic     w_busy;
  logic     w_done;

  assign w_load = clk_en && want_up &&
                  (pwr_ff == APM_FULL_DOWN || pwr_ff == APM_PART_DOWN);

  apm_timer u_wake_timer (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .load(w_load),
    .count(APM_CNT_W'(APM_WAKE_CYC)), .busy(w_busy), .done(w_done));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_ff <= APM_FULL_DOWN;
    else if (clk_en)
    begin
      unique case (pwr_ff)
        APM_FULL_DOWN,
        APM_PART_DOWN:
        begin
          if (want_up)
            pwr_ff <= APM_WAKING;
          else
            pwr_ff <= part_req ? APM_PART_DOWN : APM_FULL_DOWN;
        end
        APM_WAKING:
        begin
          if (!want_up)
            pwr_ff <= part_req ? APM_PART_DOWN : APM_FULL_DOWN;
          else if (w_done)
            pwr_ff <= APM_AWAKE;
        end
        APM_AWAKE:
        begin
          if (!want_up)
            pwr_ff <= part_req ? APM_PART_DOWN : APM_FULL_DOWN;
        end
      endcase
    end
  end

  assign awake         = (pwr_ff == APM_AWAKE);
  assign ready         = awake && !act_busy;
  assign core_power_on = (pwr_ff == APM_WAKING) || awake;
  assign ref_power_on  = core_power_on || (pwr_ff == APM_PART_DOWN);

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (clk_en && apb_rd)
    begin
      prdata <= '0;
      if (ctrl_hit)
        prdata[1:0] <= pfield_ff;
      else if (stat_hit)
      begin
        prdata[APM_ST_STATE_LSB +: 2] <= pwr_ff;
        prdata[APM_ST_BUSY_BIT]  <= act_busy;
        prdata[APM_ST_READY_BIT] <= ready;
        prdata[APM_ST_REF_BIT]   <= ref_power_on;
        prdata[APM_ST_CORE_BIT]  <= core_power_on;
        prdata[APM_ST_PCAL_BIT]  <= pcal_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence wake_seq;
    (pwr_ff == APM_WAKING) ##1 (pwr_ff == APM_WAKING);
  endsequence

  wake_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(awake) |-> $past(w_done))
    else $error("awake without completed wake delay");
  field_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> pfield_ff == APM_PF_RESET)
    else $error("power field not zero after reset");
  normal_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pfield_ff == 2'h0 && allow_s && awake && clk_en) |=> awake)
    else $error("powered down with pin high");
  field01_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pfield_ff == 2'h1 && awake && clk_en) |=> awake)
    else $error("powered down in forced normal mode");
  full_down_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pfield_ff == 2'h2 && !pcal_ff && clk_en) |=> !core_power_on)
    else $error("core powered while forced down");
  part_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr_ff == APM_PART_DOWN) |-> (ref_power_on && !core_power_on))
    else $error("partial power-down reference state wrong");
  pcal_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pcal_ff && awake && clk_en) |=> core_power_on)
    else $error("power lost during power-on calibration");
  sleep_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pfield_ff == 2'h0 && !allow_s && act_ff == APM_IDLE && !pcal_ff
     && clk_en) |=> (pwr_ff != APM_AWAKE))
    else $error("awake while sleep requested and idle");
  wake_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pwr_ff == APM_WAKING) && clk_en |-> wake_seq)
    else $error("wake phase too short");
  no_part_cal_a: assert property (@(posedge pclk) disable iff (!presetn)
    (act_ff == APM_CALIB && t_done && pfield_ff != 2'h3) |=>
    pwr_ff != APM_PART_DOWN)
    else $error("partial power-down entered after calibration");
  busy_cal_a: assert property (@(posedge pclk) disable iff (!presetn)
    (act_ff == APM_CALIB) |-> (busy && t_busy))
    else $error("busy low during calibration");

  logic unused_bits;
  assign unused_bits = ^{pwdata[31:4], power_field_hi, power_field_lo,
                         w_busy, t_busy};
endmodule : apm_power_ctrl

// [hw/apm_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module apm_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic rst_val,
  input  wire logic pin,
  output logic      level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // chain; output moves only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      level <= 1'b1;
    end
    else if (clk_en)
    begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        level <= s3_ff;
    end
  end

  logic unused_rst;
  assign unused_rst = rst_val;
endmodule : apm_sync

// [hw/apm_timer.sv]
// down counter that times a delay and flags when it expires
`timescale 1ns/100ps
module apm_timer
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         clk_en,
  input  wire logic                         load,
  input  wire logic [apm_pkg::APM_CNT_W-1:0] count,
  output logic                              busy,
  output logic                              done
);
  import apm_pkg::*;
  logic [APM_CNT_W-1:0] cnt_ff;

  // load starts a run; done pulses on the last cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= '0;
    else if (clk_en)
    begin
      if (load)
        cnt_ff <= count;
      else if (cnt_ff != '0)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = clk_en && !load && (cnt_ff == {{(APM_CNT_W-1){1'b0}}, 1'b1});
endmodule : apm_timer

// [tb/apm_host_model.sv]
// host pin model: allow pin, conversion start pin, calibration pin
`timescale 1ns/100ps
module apm_host_model
(
  input  wire logic pclk,
  output logic      power_allow,
  output logic      conversion_start_n,
  output logic      cal_req_n
);
  ////////////////////////////////////////////////////////////////////////
  // allow low, start idle high, power-on calibration requested
  initial
  begin
    power_allow        = 1'b0;
    conversion_start_n = 1'b1;
    cal_req_n          = 1'b0;
  end

  // level pins change just after a clock edge
  task set_pins(input logic allow, input logic cal);
    @(posedge pclk);
    power_allow <= allow;
    cal_req_n   <= cal;
  endtask : set_pins

  // start pulse: a long low finishes the wake before the rise
  task pulse_start(input int lo);
    @(posedge pclk);
    conversion_start_n <= 1'b0;
    repeat (lo) @(posedge pclk);
    conversion_start_n <= 1'b1;
  endtask : pulse_start
endmodule : apm_host_model

// [tb/apm_power_ctrl_bench.sv]
// self-checking bench for the power mode control block
`timescale 1ns/100ps
module apm_power_ctrl_bench;
  import apm_pkg::*;
  localparam int CAL  = 50;
  localparam int PCAL = 100;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        power_allow;
  logic        conversion_start_n;
  logic        cal_req_n;
  logic        busy;
  logic        core_power_on;
  logic        ref_power_on;
  logic        ready;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] wm;
  logic [7:0]  ua;
  int          failures;
  int          cmp_count;
  int          cyc;
  int          n;

  ////////////////////////////////////////////////////////////////////////
  // design and host pins
  apm_power_ctrl #(.POWERON_CAL_CYC(PCAL), .CAL_CYC(CAL)) dut
  (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_allow(power_allow), .conversion_start_n(conversion_start_n),
    .cal_req_n(cal_req_n), .busy(busy), .core_power_on(core_power_on),
    .ref_power_on(ref_power_on), .ready(ready)
  );
  apm_host_model host
  (
    .pclk(pclk), .power_allow(power_allow),
    .conversion_start_n(conversion_start_n), .cal_req_n(cal_req_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // 8 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // status word: bits = pcal, core, ref, ready, busy
  function automatic logic [31:0] st(input logic [1:0] s,
                                     input logic [4:0] bits);
    st = {25'h0, bits, s};
  endfunction : st

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; a read notes its expectation first
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] e, input logic [31:0] m);
    @(posedge pclk);
    if (!w)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // wait on busy low or ready high, counting cycles into n
  task wait_on(input logic for_busy);
    n = 0;
    @(negedge pclk);
    while ((for_busy ? busy === 1'h1 : ready !== 1'h1) && n < 3000)
    begin
      @(negedge pclk);
      n++;
    end
  endtask : wait_on

  task done_test(input string s);
    $display("test %s done", s);
  endtask : done_test

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  // watcher: compares each completed read with the oldest note
  always @(posedge pclk)
    if (psel && penable && pready)
    begin
      if (paddr > APM_STATUS_OFS)
        check(32'(pslverr), 32'h1);
      if (!pwrite)
      begin
        wm = msk_q.pop_front();
        check(prdata & wm, exp_q.pop_front() & wm);
      end
    end

  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      finish_test();
    end
  end

  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(34274));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h0, 5'h19), st(2'h0, 5'h19));
    apb(1'h0, APM_CTRL_OFS, 32'h0, 32'h0, 32'h3);
    repeat (PCAL + 20) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h0, 5'h00), st(2'h3, 5'h1f));
    done_test("power-on");
    host.set_pins(1'h1, 1'h0);
    wait_on(1'h0);
    check(32'(n >= 620 && n <= 645), 32'h1);
    host.set_pins(1'h0, 1'h0);
    apb(1'h1, APM_CTRL_OFS, 32'h1, 32'h0, 32'h0);
    repeat (10) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h3, 5'h0e), st(2'h3, 5'h1f));
    apb(1'h1, APM_CTRL_OFS, 32'h5, 32'h0, 32'h0);
    repeat (4) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h3, 5'h0d), st(2'h3, 5'h1f));
    wait_on(1'h1);
    done_test("wake");
    apb(1'h1, APM_CTRL_OFS, 32'h2, 32'h0, 32'h0);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h0, 5'h00), st(2'h3, 5'h1f));
    apb(1'h1, APM_CTRL_OFS, 32'h3, 32'h0, 32'h0);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h1, 5'h04), st(2'h3, 5'h1f));
    check(32'({core_power_on, ref_power_on}), 32'h1);
    apb(1'h1, APM_CTRL_OFS, 32'h1, 32'h0, 32'h0);
    wait_on(1'h0);
    apb(1'h1, APM_CTRL_OFS, 32'h9, 32'h0, 32'h0);
    wait_on(1'h1);
    check(32'(n >= CAL - 5 && n <= CAL + 5), 32'h1);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h3, 5'h0e), st(2'h3, 5'h1f));
    apb(1'h1, APM_CTRL_OFS, 32'h3, 32'h0, 32'h0);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h1, 5'h04), st(2'h3, 5'h1f));
    done_test("modes");
    ua = 8'h08 + 8'($urandom % 62) * 8'h04;
    apb(1'h1, ua, $urandom, 32'h0, 32'h0);
    apb(1'h0, ua, 32'h0, 32'h0, 32'hffffffff);
    apb(1'h0, APM_CTRL_OFS, 32'h0, 32'h3, 32'h3);
    done_test("unmapped");
    apb(1'h1, APM_CTRL_OFS, 32'h0, 32'h0, 32'h0);
    repeat (6) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h0, 5'h00), st(2'h3, 5'h1f));
    host.pulse_start(100);
    repeat (8) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, 32'h0, st(2'h0, 5'h01));
    host.pulse_start(700);
    @(negedge pclk);
    check(32'(ready), 32'h1);
    repeat (8) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h3, 5'h0d), st(2'h3, 5'h1f));
    wait_on(1'h1);
    repeat (3) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, st(2'h0, 5'h00), st(2'h3, 5'h1f));
    done_test("between");
    host.set_pins(1'h0, 1'h1);
    presetn <= 1'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    apb(1'h0, APM_STATUS_OFS, 32'h0, 32'h0, st(2'h0, 5'h11));
    apb(1'h0, APM_CTRL_OFS, 32'h0, 32'h0, 32'h3);
    done_test("no-cal");
    repeat (4) @(posedge pclk);
    finish_test();
  end
endmodule : apm_power_ctrl_bench
